// ### bench/ofd_fetch_model.sv
// fetch path model that offers instruction words to the decoder
`timescale 1ns/100ps
module ofd_fetch_model
  import ofd_pkg::*;
(
  // clock
  input  wire logic  aclk,
  // fetch handshake
  input  wire logic  instr_ready,
  output logic       instr_valid,
  output logic [15:0] instr_word,
  output ofd_class_t instr_class
);
  // idle bus at time zero
  initial begin
    instr_valid = 1'b0;
    instr_word  = 16'h0000;
    instr_class = OC_NOP;
  end
  // hold the word until taken, then scramble the bus so stale data is not reused
  task automatic send(input logic [15:0] w, input ofd_class_t c);
    @(posedge aclk);
    instr_valid <= 1'b1;
    instr_word  <= w;
    instr_class <= c;
    do @(posedge aclk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    instr_word  <= ~w;
  endtask
endmodule

// ### bench/opcode_operand_field_decoder_bench.sv
// self-checking bench for the operand field decoder
`timescale 1ns/100ps
module opcode_operand_field_decoder_bench;
  import ofd_pkg::*;
  logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic        fwe = 0, lwe = 0, awr, wr, bv, arr, rv, iv, ir, dv;
  logic [7:0]  awa = 0, ara = 0, acc = 0, lin = 0, f;
  logic [31:0] wd = 0, rd, rdat;
  logic [1:0]  rr, bresp, rresp;
  logic [3:0]  b;
  logic [11:0] s, t;
  logic [15:0] iw, w;
  ofd_class_t  ic;
  ofd_flags_t  fin = '0;
  ofd_dec_t    dec;
  int          errors = 0, checks_done = 0, cyc = 0;
  // design and fetch model; write strobes always full words
  ofd_decoder u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry), .instr_valid(iv),
    .instr_word(iw), .instr_class(ic), .instr_ready(ir), .acc_value(acc),
    .flags_we(fwe), .flags_in(fin), .latch_we(lwe), .latch_in(lin), .dec_valid(dv),
    .dec(dec), .flags(), .bank_select_register(), .program_memory_pointer(),
    .program_memory_latch(), .product_high_byte(), .product_low_byte());
  ofd_fetch_model u_fm (.aclk(aclk), .instr_ready(ir), .instr_valid(iv),
    .instr_word(iw), .instr_class(ic));
  // 4 ns clock
  initial forever #2 aclk = ~aclk;
  // cut a hang short
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      summarize;
    end
  end
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (awr !== 1'b1);
        awv <= 1'b0;
      end
      begin
        do @(posedge aclk); while (wr !== 1'b1);
        wv <= 1'b0;
      end
    join
    while (bv !== 1'b1) @(posedge aclk);
    chk(bresp, RESP_OKAY);
    bry <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk); while (rv !== 1'b1);
    d = rdat;
    r = rresp;
    rry <= 1'b0;
  endtask
  // offer a word and wait for its decode pulse
  task automatic go(input logic [15:0] x, input ofd_class_t c);
    u_fm.send(x, c);
    #1;
    while (dv !== 1'b1) @(posedge aclk) #1;
  endtask
  // expected data address: bank register or split access region
  function automatic logic [11:0] ea(input logic [15:0] x, input logic [3:0] k);
    if (x[8]) return {k, x[7:0]};
    return x[7] ? {4'hf, x[7:0]} : {4'h0, x[7:0]};
  endfunction
  // main sequence
  initial begin
    void'($urandom(40837));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axr(REG_PTR, rd, rr);
    chk(rd, 32'(PTR_RST));
    axr(8'hfc, rd, rr);
    chk(rr, RESP_SLVERR);
    axw(REG_PTR, 32'hffffffff);
    axr(REG_PTR, rd, rr);
    chk(rd, 32'h001fffff);
    b = 4'($urandom);
    axw(REG_BANK, 32'(b));
    for (int i = 0; i < 16; i++) begin
      f = (i < 2) ? 8'h7f + 8'(i) : 8'($urandom);
      w = {4'h2, 3'($urandom), (i < 2) ? 1'b0 : 1'($urandom), f};
      go(w, i[0] ? OC_BIT : OC_BYTE);
      chk(dec.data_addr, ea(w, b));
      chk(dec.rmw_read, 1'b1);
      if (i[0]) chk({dec.bit_index, dec.bit_mask}, {w[11:9], 8'h01 << w[11:9]});
      else chk(dec.dest_file, w[9]);
    end
    s = 12'($urandom);
    t = 12'($urandom);
    u_fm.send({4'h5, s}, OC_MOVE);
    go({4'hf, t}, OC_NOP);
    chk({dec.move_source_address, dec.move_target_address}, {s, t});
    go(16'hf0ab, OC_BYTE);
    chk(dec.op_class, OC_NOP);
    for (int m = 0; m < 4; m++) begin
      go({4'ha, 10'($urandom), m[1:0]}, OC_TABLE);
      chk({dec.pointer_update_mode, dec.table_addr}, {m[1:0], {21{m < 2}}});
    end
    f = 8'($urandom);
    go({8'h0e, f}, OC_LIT8);
    chk({dec.lit_width, dec.literal}, {LW_8, 12'h000, f});
    u_fm.send(16'hed5a, OC_CALL);
    go(16'hf123, OC_NOP);
    chk({dec.fast_save, dec.branch_rel, dec.branch_target}, {2'b10, 20'h1235a});
    @(posedge aclk);
    fwe <= 1'b1;
    lwe <= 1'b1;
    fin <= 5'($urandom);
    lin <= 8'($urandom);
    acc <= 8'($urandom);
    @(posedge aclk);
    fwe <= 1'b0;
    lwe <= 1'b0;
    axr(REG_FLAGS, rd, rr);
    chk(rd, 32'(fin));
    axr(REG_LATCH, rd, rr);
    chk(rd, 32'(lin));
    go({8'h0d, f}, OC_MUL);
    axr(REG_PROD, rd, rr);
    chk(rd, {16'h0000, 16'(acc) * 16'(f)});
    go(16'he080, OC_BRREL);
    chk({dec.branch_rel, dec.branch_target}, {1'b1, 20'hfff80});
    axw(REG_BANK, {28'h0000000, ~b});
    go(16'h0011, OC_RET);
    chk(dec.fast_restore, 1'b1);
    axr(REG_BANK, rd, rr);
    chk(rd, 32'(b));
    summarize;
  end
endmodule

// ### include/ofd_pkg.sv
// shared constants and types for the opcode operand field decoder
package ofd_pkg;

  // timing: oscillator periods per instruction cycle
  localparam int unsigned OSC_PER_ICYCLE = 4;

  // widths
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned FADDR_W = 12;
  localparam int unsigned BANK_W  = 4;
  localparam int unsigned PTR_W   = 21;

  // instruction word field positions
  localparam int unsigned D_BIT      = 9;
  localparam int unsigned A_BIT      = 8;
  localparam int unsigned BIT_MSB    = 11;
  localparam int unsigned BIT_LSB    = 9;
  localparam int unsigned S_CALL_BIT = 8;
  localparam int unsigned S_RET_BIT  = 0;
  localparam int unsigned TAG_MSB    = 15;
  localparam int unsigned TAG_LSB    = 12;

  // second word marker and access region split
  localparam logic [3:0] SECOND_WORD_TAG  = 4'hf;
  localparam logic [7:0] ACCESS_SPLIT     = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_BANK   = 8'h00;
  localparam logic [7:0] REG_FLAGS  = 8'h04;
  localparam logic [7:0] REG_PTR    = 8'h08;
  localparam logic [7:0] REG_LATCH  = 8'h0c;
  localparam logic [7:0] REG_PROD   = 8'h10;
  localparam logic [7:0] REG_LASTW  = 8'h14;
  localparam logic [7:0] REG_MOVE   = 8'h18;

  // reset values and bus answers
  localparam logic [3:0]  BANK_RST    = 4'h0;
  localparam logic [20:0] PTR_RST     = 21'h000000;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    OC_NOP = 4'h0, OC_BYTE = 4'h1, OC_BIT = 4'h2, OC_LIT8 = 4'h3,
    OC_PTRLOAD = 4'h4, OC_MOVE = 4'h5, OC_LONG = 4'h6, OC_CALL = 4'h7,
    OC_BRREL = 4'h8, OC_RET = 4'h9, OC_TABLE = 4'ha, OC_MUL = 4'hb
  } ofd_class_t;

  typedef enum logic [1:0] {
    PM_KEEP = 2'b00, PM_POST_INC = 2'b01, PM_POST_DEC = 2'b10, PM_PRE_INC = 2'b11
  } ofd_ptr_mode_t;

  typedef enum logic [1:0] {LW_NONE = 2'b00, LW_8 = 2'b01, LW_12 = 2'b11, LW_20 = 2'b10}
    ofd_lit_width_t;

  typedef enum logic {WS_FIRST = 1'b0, WS_SECOND = 1'b1} ofd_wstate_t;

  typedef struct packed {
    logic negative;
    logic signed_range_flag;
    logic zero;
    logic nibble_carry_flag;
    logic carry;
  } ofd_flags_t;

  typedef struct packed {
    ofd_class_t     op_class;
    logic [11:0]    data_addr;
    logic           dest_file;
    logic           rmw_read;
    logic [2:0]     bit_index;
    logic [7:0]     bit_mask;
    logic [19:0]    literal;
    ofd_lit_width_t lit_width;
    logic [11:0]    move_source_address;
    logic [11:0]    move_target_address;
    ofd_ptr_mode_t  pointer_update_mode;
    logic [20:0]    table_addr;
    logic           branch_rel;
    logic [19:0]    branch_target;
    logic           fast_save;
    logic           fast_restore;
    logic [1:0]     icycles;
  } ofd_dec_t;

  // access region map: low half to the bottom bank, high half to the top bank
  function automatic logic [11:0] ofd_access_addr(input logic [7:0] f);
    ofd_access_addr = (f < ACCESS_SPLIT) ? {ACCESS_LOW_BANK, f} : {ACCESS_HIGH_BANK, f};
  endfunction

  // classes that fetch a second word
  function automatic logic ofd_two_word(input ofd_class_t c);
    ofd_two_word = (c == OC_MOVE) || (c == OC_PTRLOAD) || (c == OC_LONG) || (c == OC_CALL);
  endfunction

endpackage

// ### logic/ofd_decoder.sv
// opcode operand field decoder with register access over axi4-lite
//
// Functional notes
// RULE1: a clear: access region, bank ignored
// RULE2: a set: bank register plus file address
// RULE3: three-bit bit position selects one bit
// RULE4: d selects accumulator or file register
// RULE5: file address field is eight bits
// RULE6: move source is twelve-bit address
// RULE7: move target is twelve-bit, bank independent
// RULE8: literals are eight, twelve or twenty bits
// RULE9: four table pointer update modes
// RULE10: relative branch signed, call/goto direct
// RULE11: fast bit saves/restores shadow registers
// RULE12: product held in high and low bytes
// RULE13: 21-bit pointer and 8-bit latch
// RULE14: don't-care bits ignored, generators write zero
// RULE15: five arithmetic status flags kept
// RULE16: stray second word executes as no-op
// RULE17: branch or return adds one cycle
// RULE18: file instructions read before writing
// RULE19: fields presented in the starting cycle
`timescale 1ns/100ps
module ofd_decoder
  import ofd_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned PHASES = OSC_PER_ICYCLE
)(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // fetch path
  input  wire logic              instr_valid,
  input  wire logic [15:0]       instr_word,
  input  wire ofd_class_t        instr_class,
  output logic                   instr_ready,
  // execution datapath inputs
  input  wire logic [7:0]        acc_value,
  input  wire logic              flags_we,
  input  wire ofd_flags_t        flags_in,
  input  wire logic              latch_we,
  input  wire logic [7:0]        latch_in,
  // decoded fields and held state
  output logic                   dec_valid,
  output ofd_dec_t               dec,
  output ofd_flags_t             flags,
  output logic [3:0]             bank_select_register,
  output logic [20:0]            program_memory_pointer,
  output logic [7:0]             program_memory_latch,
  output logic [7:0]             product_high_byte,
  output logic [7:0]             product_low_byte
);

  if (ADDR_W < 8) begin : g_check
    $error("ofd_decoder: ADDR_W must be at least 8");
  end

  // byte-lane merge of a bus write into an old value
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      wmerge[i*8 +: 8] = strb[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  logic          phase_last;
  ofd_wstate_t   wstate;
  logic [15:0]   pend_word;
  ofd_class_t    pend_class;
  logic          extra;
  ofd_flags_t    shadow_flags;
  logic [3:0]    shadow_bank;
  logic [15:0]   last_first;
  logic [15:0]   last_second;
  ofd_dec_t      next_dec;

  ofd_phase #(.PHASES(PHASES)) u_phase (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .phase_last (phase_last)
  );

  // word sequencing and operand selection
  logic          take;
  logic          tag_hit;
  logic          stray;
  logic          starts_pair;
  logic          emit;
  logic [15:0]   first_w;
  ofd_class_t    eff_class;
  ofd_ptr_mode_t mode;
  logic [20:0]   ptr_inc;
  logic [20:0]   ptr_dec;
  assign take        = instr_valid && instr_ready;
  assign tag_hit     = instr_word[TAG_MSB:TAG_LSB] == SECOND_WORD_TAG;
  // RULE16: stray second word
  assign stray       = (wstate == WS_FIRST) && tag_hit;
  assign starts_pair = take && (wstate == WS_FIRST) && !stray && ofd_two_word(instr_class);
  assign emit        = take && !starts_pair;
  assign first_w     = (wstate == WS_SECOND) ? pend_word : instr_word;
  assign eff_class   = stray ? OC_NOP :
                       (wstate == WS_SECOND) ? (tag_hit ? pend_class : OC_NOP) : instr_class;
  assign mode        = ofd_ptr_mode_t'(first_w[1:0]);
  assign ptr_inc     = program_memory_pointer + 21'h000001;
  assign ptr_dec     = program_memory_pointer - 21'h000001;

  // RULE14: don't-care bits dropped
  // field extraction; unused bits of each format never reach a dec field
  always_comb begin
    next_dec = '0;
    next_dec.op_class = eff_class;
    next_dec.icycles = 2'd1;
    case (eff_class)
      OC_BYTE, OC_BIT: begin
        // RULE1: access region
        // RULE2: bank register select
        // RULE5: eight-bit file field
        next_dec.data_addr = first_w[A_BIT] ? {bank_select_register, first_w[7:0]}
                                            : ofd_access_addr(first_w[7:0]);
        // RULE18: read before write
        next_dec.rmw_read = 1'b1;
        // RULE4: destination select
        next_dec.dest_file = (eff_class == OC_BIT) || first_w[D_BIT];
        if (eff_class == OC_BIT) begin
          // RULE3: bit position
          next_dec.bit_index = first_w[BIT_MSB:BIT_LSB];
          next_dec.bit_mask = 8'h01 << first_w[BIT_MSB:BIT_LSB];
        end
      end
      OC_LIT8, OC_MUL: begin
        // RULE8: eight-bit literal
        next_dec.literal = {12'h000, first_w[7:0]};
        next_dec.lit_width = LW_8;
      end
      OC_PTRLOAD: begin
        // RULE8: twelve-bit pointer literal
        next_dec.literal = {8'h00, first_w[3:0], instr_word[7:0]};
        next_dec.lit_width = LW_12;
        next_dec.icycles = 2'd2;
      end
      OC_MOVE: begin
        // RULE6: move source address
        // RULE7: move target address
        next_dec.move_source_address = first_w[11:0];
        next_dec.move_target_address = instr_word[11:0];
        next_dec.rmw_read = 1'b1;
        next_dec.icycles = 2'd2;
      end
      OC_LONG, OC_CALL: begin
        // RULE10: direct target
        next_dec.literal = {instr_word[11:0], first_w[7:0]};
        next_dec.lit_width = LW_20;
        next_dec.branch_target = {instr_word[11:0], first_w[7:0]};
        // RULE11: fast call
        next_dec.fast_save = (eff_class == OC_CALL) && first_w[S_CALL_BIT];
        next_dec.icycles = 2'd2;
      end
      OC_BRREL: begin
        // RULE10: signed displacement
        next_dec.branch_rel = 1'b1;
        next_dec.branch_target = {{12{first_w[7]}}, first_w[7:0]};
        // RULE17: extra cycle
        next_dec.icycles = 2'd2;
      end
      OC_RET: begin
        // RULE11: fast return
        next_dec.fast_restore = first_w[S_RET_BIT];
        next_dec.icycles = 2'd2;
      end
      OC_TABLE: begin
        // RULE9: pointer mode
        next_dec.pointer_update_mode = mode;
        next_dec.table_addr = (mode == PM_PRE_INC) ? ptr_inc : program_memory_pointer;
      end
      default: begin
        next_dec.op_class = OC_NOP;
      end
    endcase
  end

  // sequencing: pending first word, extra cycle, ready at phase boundary
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate <= WS_FIRST;
      pend_word <= 16'h0000;
      pend_class <= OC_NOP;
      extra <= 1'b0;
      instr_ready <= 1'b0;
    end else begin
      if (starts_pair) begin
        wstate <= WS_SECOND;
        pend_word <= instr_word;
        pend_class <= instr_class;
      end else if (emit) begin
        wstate <= WS_FIRST;
      end
      // RULE17: hold off one cycle
      if (emit && (eff_class == OC_BRREL || eff_class == OC_RET)) begin
        extra <= 1'b1;
      end else if (phase_last) begin
        extra <= 1'b0;
      end
      // one instruction taken per cycle of PHASES periods
      instr_ready <= phase_last && !extra;
    end
  end

  // RULE19: fields out in starting cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dec_valid <= 1'b0;
      dec <= '0;
      last_first <= 16'h0000;
      last_second <= 16'h0000;
    end else begin
      dec_valid <= emit;
      if (emit) begin
        dec <= next_dec;
        last_first <= first_w;
        last_second <= instr_word;
      end
    end
  end

  // bus write path: address and data taken in either order
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_fire;
  logic [7:0]        wr_off;
  logic              wr_map;
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_off  = aw_addr[7:0];
  assign wr_map  = (wr_off == REG_BANK) || (wr_off == REG_FLAGS) || (wr_off == REG_PTR) ||
                   (wr_off == REG_LATCH) || (wr_off == REG_PROD) || (wr_off == REG_LASTW) ||
                   (wr_off == REG_MOVE);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_map && aw_addr[ADDR_W-1:0] == ADDR_W'(wr_off)) ? RESP_OKAY
                                                                          : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register next values; hardware events win over a same-cycle bus write
  logic        sw_we;
  ofd_flags_t  next_flags;
  logic [3:0]  next_bank;
  logic [20:0] next_ptr;
  logic [7:0]  next_latch;
  logic        do_restore;
  assign sw_we      = wr_fire && (aw_addr[ADDR_W-1:0] == ADDR_W'(wr_off));
  assign do_restore = emit && next_dec.fast_restore;
  // RULE11: restore from shadow set
  assign next_bank  = do_restore ? shadow_bank :
                      (sw_we && wr_off == REG_BANK) ? 4'(wmerge(32'(bank_select_register),
                                                             w_data, w_strb)) :
                      bank_select_register;
  // RULE15: five status flags
  assign next_flags = do_restore ? shadow_flags : flags_we ? flags_in :
                      (sw_we && wr_off == REG_FLAGS) ?
                        ofd_flags_t'(5'(wmerge(32'(flags), w_data, w_strb))) : flags;
  // RULE9: pointer update modes
  assign next_ptr   = (emit && eff_class == OC_TABLE) ?
                        ((mode == PM_POST_DEC) ? ptr_dec :
                         (mode == PM_KEEP) ? program_memory_pointer : ptr_inc) :
                      (sw_we && wr_off == REG_PTR) ?
                        21'(wmerge(32'(program_memory_pointer), w_data, w_strb)) :
                      program_memory_pointer;
  assign next_latch = latch_we ? latch_in :
                      (sw_we && wr_off == REG_LATCH) ?
                        8'(wmerge(32'(program_memory_latch), w_data, w_strb)) :
                      program_memory_latch;

  // RULE13: pointer and latch storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_select_register <= BANK_RST;
      flags <= '0;
      program_memory_pointer <= PTR_RST;
      program_memory_latch <= 8'h00;
    end else begin
      bank_select_register <= next_bank;
      flags <= next_flags;
      program_memory_pointer <= next_ptr;
      program_memory_latch <= next_latch;
    end
  end

  // RULE11: shadow save on fast call
  // RULE12: product split into two bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow_flags <= '0;
      shadow_bank <= BANK_RST;
      {product_high_byte, product_low_byte} <= 16'h0000;
    end else begin
      if (emit && next_dec.fast_save) begin
        shadow_flags <= flags;
        shadow_bank <= bank_select_register;
      end
      if (emit && eff_class == OC_MUL) begin
        {product_high_byte, product_low_byte} <= 16'(acc_value) * 16'(first_w[7:0]);
      end
    end
  end

  // bus read path; unmapped offsets answer slverr with zero data
  logic [31:0] rd_data;
  logic        rd_map;
  assign rd_map = s_axi_araddr[ADDR_W-1:0] == ADDR_W'(s_axi_araddr[7:0]);
  always_comb begin
    rd_data = 32'h00000000;
    case (s_axi_araddr[7:0])
      REG_BANK:  rd_data = 32'(bank_select_register);
      REG_FLAGS: rd_data = 32'(flags);
      REG_PTR:   rd_data = 32'(program_memory_pointer);
      REG_LATCH: rd_data = 32'(program_memory_latch);
      REG_PROD:  rd_data = {16'h0000, product_high_byte, product_low_byte};
      REG_LASTW: rd_data = {last_second, last_first};
      REG_MOVE:  rd_data = {4'h0, dec.move_target_address, 4'h0, dec.move_source_address};
      default:   rd_data = 32'h00000000;
    endcase
  end
  logic rd_known;
  assign rd_known = rd_map && ((s_axi_araddr[7:0] == REG_BANK) ||
                    (s_axi_araddr[7:0] == REG_FLAGS) || (s_axi_araddr[7:0] == REG_PTR) ||
                    (s_axi_araddr[7:0] == REG_LATCH) || (s_axi_araddr[7:0] == REG_PROD) ||
                    (s_axi_araddr[7:0] == REG_LASTW) || (s_axi_araddr[7:0] == REG_MOVE));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_known ? rd_data : 32'h00000000;
        s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // checks on decoded fields against the word that produced them
  property p_access_region;
    @(posedge aclk) disable iff (!aresetn)
    (emit && (eff_class == OC_BYTE || eff_class == OC_BIT) && !first_w[A_BIT])
      |=> dec.data_addr == ofd_access_addr($past(first_w[7:0]));
  endproperty
  a_access_region: assert property (p_access_region) else $error("access region wrong"); // RULE1
  property p_bank_addr;
    @(posedge aclk) disable iff (!aresetn)
    (emit && eff_class == OC_BYTE && first_w[A_BIT])
      |=> dec.data_addr == {$past(bank_select_register), $past(first_w[7:0])};
  endproperty
  a_bank_addr: assert property (p_bank_addr) else $error("banked address wrong"); // RULE2
  property p_bit_mask;
    @(posedge aclk) disable iff (!aresetn)
    (dec_valid && dec.op_class == OC_BIT)
      |-> $onehot(dec.bit_mask) && dec.bit_mask == (8'h01 << last_first[BIT_MSB:BIT_LSB]);
  endproperty
  a_bit_mask: assert property (p_bit_mask) else $error("bit mask wrong"); // RULE3
  property p_dest;
    @(posedge aclk) disable iff (!aresetn)
    (dec_valid && dec.op_class == OC_BYTE) |-> dec.dest_file == last_first[D_BIT];
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong"); // RULE4
  property p_move;
    @(posedge aclk) disable iff (!aresetn)
    (dec_valid && dec.op_class == OC_MOVE) |-> dec.move_source_address == last_first[11:0]
      && dec.move_target_address == last_second[11:0];
  endproperty
  a_move: assert property (p_move) else $error("move addresses wrong"); // RULE7
  property p_ptr_mode;
    @(posedge aclk) disable iff (!aresetn)
    (dec_valid && dec.op_class == OC_TABLE) |->
      program_memory_pointer == ((dec.pointer_update_mode == PM_POST_INC) ?
        dec.table_addr + 21'h000001 : (dec.pointer_update_mode == PM_POST_DEC) ?
        dec.table_addr - 21'h000001 : dec.table_addr);
  endproperty
  a_ptr_mode: assert property (p_ptr_mode) else $error("pointer update wrong"); // RULE9
  property p_restore;
    @(posedge aclk) disable iff (!aresetn)
    (dec_valid && dec.fast_restore) |-> flags == $past(shadow_flags);
  endproperty
  a_restore: assert property (p_restore) else $error("fast restore wrong"); // RULE11
  property p_product;
    @(posedge aclk) disable iff (!aresetn)
    (emit && eff_class == OC_MUL) |=>
      {product_high_byte, product_low_byte} == $past(acc_value) * $past(first_w[7:0]);
  endproperty
  a_product: assert property (p_product) else $error("product wrong"); // RULE12
  property p_stray;
    @(posedge aclk) disable iff (!aresetn)
    (take && stray) |=> dec_valid && dec.op_class == OC_NOP;
  endproperty
  a_stray: assert property (p_stray) else $error("stray second word not nop"); // RULE16
  property p_extra;
    @(posedge aclk) disable iff (!aresetn)
    (dec_valid && dec.op_class == OC_BRREL) |-> !instr_ready [*7] ##1 instr_ready;
  endproperty
  a_extra: assert property (p_extra) else $error("branch extra cycle wrong"); // RULE17
  property p_same_cycle;
    @(posedge aclk) disable iff (!aresetn)
    emit |=> dec_valid && !instr_ready;
  endproperty
  a_same_cycle: assert property (p_same_cycle) else $error("decode late"); // RULE19

endmodule

// ### logic/ofd_phase.sv
// instruction cycle phase counter
`timescale 1ns/100ps
module ofd_phase
  import ofd_pkg::*;
#(
  parameter int unsigned PHASES = OSC_PER_ICYCLE
)(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // phase marker
  output logic      phase_last
);

  localparam int unsigned CW = (PHASES > 2) ? $clog2(PHASES) : 1;
  localparam logic [CW-1:0] LAST = CW'(PHASES - 1);

  // the ready handshake needs distinct first and last phases
  if (PHASES < 2) begin : g_check
    $error("ofd_phase: PHASES must be at least 2");
  end

  logic [CW-1:0] phase;
  logic [CW-1:0] next_phase;

  assign next_phase = (phase == LAST) ? '0 : phase + CW'(1);
  assign phase_last = (phase == LAST);

  // free running count of oscillator periods
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= '0;
    end else begin
      phase <= next_phase;
    end
  end

endmodule
